// ===== pkg/eif_pkg.sv
package eif_pkg;
    // register byte addresses on the axi4-lite slave
    localparam logic [7:0] EIF_EVT_ADDR    = 8'h00; // event ident (read)
    localparam logic [7:0] EIF_QCTL_ADDR   = 8'h04; // queue control (write)
    localparam logic [7:0] EIF_MODE_ADDR   = 8'h08; // mode / config
    localparam logic [7:0] EIF_ACK_ADDR    = 8'h0C; // extended event ack, write 1s
    localparam logic [7:0] EIF_STAT_ADDR   = 8'h10; // control state readback
    // queue control fields
    localparam int EIF_QC_FIFOEN = 0;
    localparam int EIF_QC_RXRST  = 1;
    localparam int EIF_QC_TXRST  = 2;
    localparam int EIF_QC_TXTH   = 4;
    localparam int EIF_QC_RXTH   = 6;
    // mode register fields, and the ack register's timer clear bit
    localparam int EIF_MD_EXT    = 0;
    localparam int EIF_MD_OPM    = 1;   // 3 bits
    localparam int EIF_MD_IRMSEL = 4;
    localparam int EIF_MD_DEEP   = 5;   // 1 = 32-level fifos
    localparam int EIF_MD_ISADMA = 6;
    localparam int EIF_MD_TMRCLR = 7;   // ack register bit 7, write 1 clears the timer flag
    // legacy codes
    localparam logic [3:0] EIF_CODE_NONE = 4'h1;
    localparam logic [3:0] EIF_CODE_LS   = 4'h6;
    localparam logic [3:0] EIF_CODE_RXHL = 4'h4;
    localparam logic [3:0] EIF_CODE_RXTO = 4'hC;
    localparam logic [3:0] EIF_CODE_TXLL = 4'h2;
    localparam logic [3:0] EIF_CODE_MS   = 4'h0;
    localparam logic [7:0] EIF_EXT_RESET = 8'h22;
    localparam logic [7:0] EIF_QCTL_RESET = 8'h00;
    localparam logic [7:0] EIF_MODE_RESET = 8'h00;
    localparam int EIF_TIMEOUT_CHARS = 4;
    typedef enum logic [2:0] {
        EIF_UART = 3'b000,
        EIF_SHIR = 3'b001,
        EIF_SIR  = 3'b010,
        EIF_MIR  = 3'b011,
        EIF_FIR  = 3'b100,
        EIF_CREM = 3'b101
    } eif_mode_t;
endpackage

// ===== rtl/eif_thresh.sv
`timescale 1ns/1ns
module eif_thresh
    import eif_pkg::*;
#(
    parameter int LW = 6
) (
    input  wire logic [1:0]    txSel,   // tx threshold select
    input  wire logic [1:0]    rxSel,   // rx threshold select
    input  wire logic          deep,    // 32-level fifos
    input  wire logic [LW-1:0] txLevel, // tx fifo level
    input  wire logic [LW-1:0] rxLevel, // rx fifo level
    output logic               txBelow, // tx level below threshold
    output logic               rxAtOrAbove // rx level at or above
);
    logic [LW-1:0] txTh;
    logic [LW-1:0] rxTh;
    always_comb begin
        case ({deep, txSel})
            3'b000: txTh = LW'(1);
            3'b001: txTh = LW'(3);
            3'b010: txTh = LW'(9);
            3'b011: txTh = LW'(13);
            3'b100: txTh = LW'(1);
            3'b101: txTh = LW'(7);
            3'b110: txTh = LW'(17);
            default: txTh = LW'(25);
        endcase
        case ({deep, rxSel})
            3'b000: rxTh = LW'(1);
            3'b001: rxTh = LW'(4);
            3'b010: rxTh = LW'(8);
            3'b011: rxTh = LW'(14);
            3'b100: rxTh = LW'(1);
            3'b101: rxTh = LW'(8);
            3'b110: rxTh = LW'(16);
            default: rxTh = LW'(26);
        endcase
        txBelow = txLevel < txTh;
        rxAtOrAbove = rxLevel >= rxTh;
    end
endmodule

// ===== rtl/eif_core.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module eif_core
    import eif_pkg::*;
#(
    parameter int LW = 6
) (
    input  wire logic          mclk,          // 25 MHz clock
    input  wire logic          rst,           // async reset, high
    input  wire logic [7:0]    s_axi_awaddr,  // write address
    input  wire logic          s_axi_awvalid, // write address valid
    output logic               s_axi_awready, // write address ready
    input  wire logic [31:0]   s_axi_wdata,   // write data
    input  wire logic [3:0]    s_axi_wstrb,   // write strobes
    input  wire logic          s_axi_wvalid,  // write data valid
    output logic               s_axi_wready,  // write data ready
    output logic [1:0]         s_axi_bresp,   // write response
    output logic               s_axi_bvalid,  // write response valid
    input  wire logic          s_axi_bready,  // write response ready
    input  wire logic [7:0]    s_axi_araddr,  // read address
    input  wire logic          s_axi_arvalid, // read address valid
    output logic               s_axi_arready, // read address ready
    output logic [31:0]        s_axi_rdata,   // read data
    output logic [1:0]         s_axi_rresp,   // read response
    output logic               s_axi_rvalid,  // read data valid
    input  wire logic          s_axi_rready,  // read data ready
    input  wire logic          rxDataRead,    // rx port read pulse
    input  wire logic          txDataWrite,   // tx port write pulse
    input  wire logic          linkStatusRead, // link status reg read pulse
    input  wire logic          modemStatusRead, // modem status reg read pulse
    input  wire logic          rxHoldFull,    // rx holding reg full
    input  wire logic          txHoldEmpty,   // tx holding reg empty
    input  wire logic [LW-1:0] rxLevel,       // rx fifo level
    input  wire logic [LW-1:0] txLevel,       // tx fifo level
    input  wire logic          rxTimeout,     // 4-char rx timeout level
    input  wire logic          lineErrBottom, // parity/framing/break at bottom
    input  wire logic          overrun,       // rx overrun pulse
    input  wire logic          underrun,      // tx underrun pulse
    input  wire logic          frameEndBottom, // last frame byte at bottom
    input  wire logic          txHaltFrame,   // tx halted at frame end pulse
    input  wire logic [3:0]    modemDelta,    // modem status bits 3..0
    input  wire logic          dmaTc,         // dma terminal count pulse
    input  wire logic          txEmpty,       // transmitter empty level
    input  wire logic          pipeLoad,      // pipeline load pulse
    input  wire logic          statQueueHit,  // status queue level/timeout
    input  wire logic          timerZero,     // protocol timer reached 0
    output logic               rxSoftReset_ff, // rx soft reset pulse
    output logic               txSoftReset_ff, // tx soft reset pulse
    output logic               fifosOn_ff,    // fifos enabled
    output logic               rxDmaReq_ff    // rx dma request
);
    logic [7:0] qctl_ff;
    logic [7:0] mode_ff;
    logic [7:0] ext_ff;
    logic       lsPend_ff;
    logic       txlPend_ff;
    logic       msPend_ff;
    logic       awHeld_ff;
    logic       wHeld_ff;
    logic [7:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic       txBelow;
    logic       rxHit;
    logic       doWrite;
    logic       doRead;
    logic [7:0] rdAddr;
    logic [3:0] code;
    logic [7:0] eventView;
    logic [2:0] opm;
    logic       fastMode;
    logic       irMode;

    eif_thresh #(.LW(LW)) eif_thresh_i (
        .txSel      (qctl_ff[EIF_QC_TXTH +: 2]),
        .rxSel      (qctl_ff[EIF_QC_RXTH +: 2]),
        .deep       (mode_ff[EIF_MD_DEEP]),
        .txLevel    (txLevel),
        .rxLevel    (rxLevel),
        .txBelow    (txBelow),
        .rxAtOrAbove(rxHit)
    );

    function automatic logic isMode(input logic [2:0] m, input eif_mode_t t);
        return m == t;
    endfunction

    assign opm      = mode_ff[EIF_MD_OPM +: 3];
    assign fastMode = isMode(opm, EIF_MIR) || isMode(opm, EIF_FIR) || isMode(opm, EIF_CREM);
    assign irMode   = !isMode(opm, EIF_UART);

    // axi write: address and data taken independently, response after both
    assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    assign doRead  = s_axi_arvalid && s_axi_arready;
    assign rdAddr  = s_axi_araddr;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awHeld_ff     <= 1'b0;
            wHeld_ff      <= 1'b0;
            awAddr_ff     <= 8'h00;
            wData_ff      <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= !awHeld_ff && !s_axi_awready;
            s_axi_wready  <= !wHeld_ff && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr_ff == EIF_EVT_ADDR || awAddr_ff == EIF_QCTL_ADDR ||
                                 awAddr_ff == EIF_MODE_ADDR || awAddr_ff == EIF_ACK_ADDR ||
                                 awAddr_ff == EIF_STAT_ADDR) ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHeld_ff    <= 1'b0;
                wHeld_ff     <= 1'b0;
            end
        end
    end

    // strobe lane 0 is the only one that carries register bits
    logic wrQctl;
    logic wrMode;
    logic wrAck;
    assign wrQctl = doWrite && s_axi_wstrb[0] && (awAddr_ff == EIF_QCTL_ADDR);
    assign wrMode = doWrite && s_axi_wstrb[0] && (awAddr_ff == EIF_MODE_ADDR);
    assign wrAck  = doWrite && s_axi_wstrb[0] && (awAddr_ff == EIF_ACK_ADDR);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            qctl_ff        <= EIF_QCTL_RESET;
            rxSoftReset_ff <= 1'b0;
            txSoftReset_ff <= 1'b0;
            fifosOn_ff     <= 1'b0;
        end else begin
            rxSoftReset_ff <= wrQctl && wData_ff[EIF_QC_RXRST];
            txSoftReset_ff <= wrQctl && wData_ff[EIF_QC_TXRST];
            if (wrQctl) begin
                qctl_ff <= {wData_ff[7:3], 2'b00, wData_ff[0]};
            end
            fifosOn_ff <= fastMode || (wrQctl ? wData_ff[EIF_QC_FIFOEN] :
                                       qctl_ff[EIF_QC_FIFOEN]);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_ff <= EIF_MODE_RESET;
        end else if (wrMode) begin
            mode_ff <= {1'b0, wData_ff[6:0]};
        end
    end

    // extended event sources, level or pulse
    logic [7:0] extSet;
    always_comb begin
        extSet[0] = fifosOn_ff ? (rxHit || rxTimeout) : rxHoldFull;
        extSet[1] = fifosOn_ff ? txBelow : txHoldEmpty;
        if (isMode(opm, EIF_CREM)) begin
            extSet[2] = overrun || underrun;
        end else if (isMode(opm, EIF_MIR) || isMode(opm, EIF_FIR)) begin
            extSet[2] = frameEndBottom || overrun || underrun || txHaltFrame;
        end else begin
            extSet[2] = lineErrBottom || overrun;
        end
        extSet[3] = |modemDelta;
        extSet[4] = mode_ff[EIF_MD_ISADMA] && dmaTc;
        if (isMode(opm, EIF_MIR) || isMode(opm, EIF_FIR) || isMode(opm, EIF_SIR)) begin
            extSet[5] = txEmpty || pipeLoad;
        end else begin
            extSet[5] = txEmpty;
        end
        extSet[6] = (isMode(opm, EIF_MIR) || isMode(opm, EIF_FIR)) && statQueueHit;
        extSet[7] = timerZero;
    end

    logic evtRead;
    assign evtRead = doRead && (rdAddr == EIF_EVT_ADDR);

    // set wins over clear for every sticky flag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_ff <= EIF_EXT_RESET;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (extSet[i]) begin
                    ext_ff[i] <= 1'b1;
                end else if (i == 4) begin
                    if (evtRead && mode_ff[EIF_MD_EXT]) ext_ff[i] <= 1'b0;
                end else if (i == 7) begin
                    if (wrAck && wData_ff[EIF_MD_TMRCLR]) ext_ff[i] <= 1'b0;
                end else if (i == 6) begin
                    ext_ff[i] <= 1'b0;
                end else if (wrAck && wData_ff[i]) begin
                    ext_ff[i] <= 1'b0;
                end
            end
        end
    end

    // legacy pending latches for events cleared by a read (tx low level also by a tx write)
    logic txEmptyNow;
    logic txEmptyWas_ff;
    assign txEmptyNow = fifosOn_ff ? (txLevel == '0) : txHoldEmpty;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lsPend_ff     <= 1'b0;
            txlPend_ff    <= 1'b0;
            msPend_ff     <= 1'b0;
            txEmptyWas_ff <= 1'b0;
        end else begin
            if (lineErrBottom || overrun) lsPend_ff <= 1'b1;
            else if (linkStatusRead) lsPend_ff <= 1'b0;
            txEmptyWas_ff <= txEmptyNow;
            if (txEmptyNow && !txEmptyWas_ff) txlPend_ff <= 1'b1;
            else if (txDataWrite) txlPend_ff <= 1'b0;
            else if (evtRead && !mode_ff[EIF_MD_EXT] && code == EIF_CODE_TXLL)
                txlPend_ff <= 1'b0;
            if (|modemDelta) msPend_ff <= 1'b1;
            else if (modemStatusRead) msPend_ff <= 1'b0;
        end
    end

    logic rxhlNow;
    logic rxtoNow;
    assign rxhlNow = fifosOn_ff ? rxHit : rxHoldFull;
    assign rxtoNow = fifosOn_ff && rxTimeout && !rxDataRead;

    always_comb begin
        if (lsPend_ff) code = EIF_CODE_LS;
        else if (rxtoNow) code = EIF_CODE_RXTO;
        else if (rxhlNow) code = EIF_CODE_RXHL;
        else if (txlPend_ff) code = EIF_CODE_TXLL;
        else if (msPend_ff) code = EIF_CODE_MS;
        else code = EIF_CODE_NONE;
    end

    always_comb begin
        if (mode_ff[EIF_MD_EXT]) begin
            eventView = ext_ff;
            if (irMode && mode_ff[EIF_MD_IRMSEL]) eventView[3] = 1'b0;
        end else begin
            eventView = {{2{fifosOn_ff}}, 2'b00, code};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (doRead) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'b00;
                case (rdAddr)
                    EIF_EVT_ADDR:  s_axi_rdata <= {24'h000000, eventView};
                    EIF_QCTL_ADDR: s_axi_rdata <= 32'h0000_0000;
                    EIF_MODE_ADDR: s_axi_rdata <= {24'h000000, mode_ff};
                    EIF_ACK_ADDR:  s_axi_rdata <= 32'h0000_0000;
                    EIF_STAT_ADDR: s_axi_rdata <= {24'h000000, qctl_ff[7:3], 2'b00, fifosOn_ff};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxDmaReq_ff <= 1'b0;
        end else begin
            rxDmaReq_ff <= fifosOn_ff && (rxHit || rxTimeout);
        end
    end

    property p_soft_rx;
        @(posedge mclk) disable iff (rst)
        wrQctl && wData_ff[EIF_QC_RXRST] |=> rxSoftReset_ff ##1 !rxSoftReset_ff || wrQctl;
    endproperty
    a_soft_rx: assert property (p_soft_rx) else $error("rx soft reset not one pulse");
    property p_fast_fifo;
        @(posedge mclk) disable iff (rst)
        fastMode |=> fifosOn_ff;
    endproperty
    a_fast_fifo: assert property (p_fast_fifo) else $error("fifos off in fast mode");
    property p_timer_set;
        @(posedge mclk) disable iff (rst)
        timerZero |=> ext_ff[7];
    endproperty
    a_timer_set: assert property (p_timer_set) else $error("timer flag not set");
    property p_timer_hold;
        @(posedge mclk) disable iff (rst)
        ext_ff[7] && !(wrAck && wData_ff[EIF_MD_TMRCLR]) |=> ext_ff[7];
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("timer flag lost");
    property p_ls_top;
        @(posedge mclk) disable iff (rst)
        lsPend_ff |-> code == EIF_CODE_LS;
    endproperty
    a_ls_top: assert property (p_ls_top) else $error("line status not top");
    property p_ipf;
        @(posedge mclk) disable iff (rst)
        (code[0] == 1'b1) |-> !lsPend_ff && !txlPend_ff && !msPend_ff && !rxhlNow;
    endproperty
    a_ipf: assert property (p_ipf) else $error("pending flag wrong");
    property p_dma_req;
        @(posedge mclk) disable iff (rst)
        rxDmaReq_ff |-> $past(fifosOn_ff && (rxHit || rxTimeout));
    endproperty
    a_dma_req: assert property (p_dma_req) else $error("dma request without cause");
    property p_ms_clear;
        @(posedge mclk) disable iff (rst)
        modemStatusRead && !(|modemDelta) |=> !msPend_ff;
    endproperty
    a_ms_clear: assert property (p_ms_clear) else $error("modem pending not cleared");
    property p_tc_set;
        @(posedge mclk) disable iff (rst)
        dmaTc && mode_ff[EIF_MD_ISADMA] |=> ext_ff[4];
    endproperty
    a_tc_set: assert property (p_tc_set) else $error("terminal count flag not set");
endmodule

// ===== bench/eif_far_model.sv
`timescale 1ns/1ns
module eif_far_model (
    input  wire logic       mclk,      // device clock
    input  wire logic       rst,       // async reset, high
    input  wire logic       dmaEn,     // dma channel armed
    input  wire logic       pushRx,    // one char arrives
    input  wire logic       rxDmaReq,  // request from device
    input  wire logic       rxClear,   // rx soft reset pulse
    output logic [5:0]      rxLevel,   // rx fifo level
    output logic            rxDataRead // dma read strobe
);
    // one read per two cycles so the registered request can drop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxLevel    <= 6'h00;
            rxDataRead <= 1'b0;
        end else begin
            rxDataRead <= dmaEn && rxDmaReq && !rxDataRead && rxLevel != 6'h00;
            if (rxClear)
                rxLevel <= 6'h00;
            else
                rxLevel <= rxLevel + 6'(pushRx) - 6'(rxDataRead);
        end
    end
endmodule

// ===== bench/eif_core_tb.sv
`timescale 1ns/1ns
module eif_core_tb;
    import eif_pkg::*;
    logic        mclk, rst, dmaEn, pushRx, rxDataRead, rx_soft_reset, tx_soft_reset, fifosOn, dmaReq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, br, rr;
    logic [5:0]  rxLevel, txLevel;
    logic [3:0]  modemDelta;
    logic [15:0] src;
    int          badCount, comparisons, n, rc, tc;
    // per source: op mode, source bit, expected flags
    logic [2:0]  tblOpm [10] = '{3'h0, 3'h0, 3'h3, 3'h3, 3'h4, 3'h5, 3'h5, 3'h0, 3'h2, 3'h3};
    int          tblSrc [10] = '{1, 0, 2, 3, 4, 0, 1, 6, 7, 8};
    logic [7:0]  tblExp [10] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h00, 8'h04, 8'h20,
                                 8'h20, 8'h40};

    eif_core #(.LW(6)) eif_core_i (
        .mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxDataRead, .txDataWrite(src[12]),
        .linkStatusRead(src[10]), .modemStatusRead(src[11]), .rxHoldFull(src[14]),
        .txHoldEmpty(src[15]), .rxLevel, .txLevel, .rxTimeout(src[13]),
        .lineErrBottom(src[0]), .overrun(src[1]), .underrun(src[2]),
        .frameEndBottom(src[3]), .txHaltFrame(src[4]), .modemDelta, .dmaTc(src[5]),
        .txEmpty(src[6]), .pipeLoad(src[7]), .statQueueHit(src[8]), .timerZero(src[9]),
        .rxSoftReset_ff(rx_soft_reset), .txSoftReset_ff(tx_soft_reset), .fifosOn_ff(fifosOn),
        .rxDmaReq_ff(dmaReq)
    );

    eif_far_model eif_far_model_i (
        .mclk, .rst, .dmaEn, .pushRx, .rxDmaReq(dmaReq), .rxClear(rx_soft_reset), .rxLevel,
        .rxDataRead
    );

    // soft reset pulse stands with the write response, so count it all along
    always @(posedge mclk) begin
        rc <= rc + int'(rx_soft_reset === 1'b1);
        tc <= tc + int'(tx_soft_reset === 1'b1);
    end

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic finishTest();
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic limit(input int k);
        if (k >= 100) begin
            badCount++;
            $display("mismatch wait expected answer seen none");
            finishTest();
        end
    endtask

    // bready rides with the request; response only follows both handshakes
    task automatic axWrite(input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && k < 100);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
        limit(k);
    endtask

    task automatic axRead(input logic [7:0] a);
        int k;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && k < 100);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        limit(k);
    endtask

    task automatic expEvt(input logic [7:0] e);
        axRead(EIF_EVT_ADDR);
        chkVal("event register", {24'h000000, e}, rd);
    endtask

    task automatic hit(input int k);
        @(posedge mclk);
        src[k] <= 1'b1;
        @(posedge mclk);
        src[k] <= 1'b0;
    endtask

    task automatic pushChar(input int k);
        repeat (k) begin
            @(posedge mclk);
            pushRx <= 1'b1;
            @(posedge mclk);
            pushRx <= 1'b0;
        end
        repeat (2) @(posedge mclk);
    endtask

    initial begin
        {rst, dmaEn, pushRx, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h20;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
        {s_axi_wdata, src, modemDelta} = 52'h0;
        txLevel = 6'h01;
        badCount = 0;
        comparisons = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        expEvt(8'h01);
        @(posedge mclk);
        src[14] <= 1'b1;
        src[15] <= 1'b1;
        expEvt(8'h04);
        src[14] <= 1'b0;
        hit(12);
        expEvt(8'h01);
        src[15] <= 1'b0;
        axRead(8'h14);
        chkVal("unmapped read response", 32'h2, {30'h0, rr});
        axWrite(8'h14, 8'h00);
        chkVal("unmapped write response", 32'h2, {30'h0, br});
        axWrite(EIF_QCTL_ADDR, 8'h41);
        chkVal("fifos on", 32'h1, {31'h0, fifosOn});
        expEvt(8'hC1);
        pushChar(1);
        chkVal("rx dma request", 32'h0, {31'h0, dmaReq});
        @(posedge mclk);
        src[13] <= 1'b1;
        expEvt(8'hCC);
        src[13] <= 1'b0;
        pushChar(3);
        chkVal("rx dma request", 32'h1, {31'h0, dmaReq});
        expEvt(8'hC4);
        hit(0);
        expEvt(8'hC6);
        hit(10);
        expEvt(8'hC4);
        @(posedge mclk);
        txLevel <= 6'h00;
        dmaEn <= 1'b1;
        for (n = 0; n < 100 && dmaReq !== 1'b0; n++) @(posedge mclk);
        limit(n);
        expEvt(8'hC2);
        expEvt(8'hC1);
        modemDelta <= 4'h1;
        expEvt(8'hC0);
        modemDelta <= 4'h0;
        hit(11);
        expEvt(8'hC1);
        axWrite(EIF_QCTL_ADDR, 8'h07);
        repeat (8) @(posedge mclk);
        chkVal("rx soft reset cycles", 32'h1, rc);
        chkVal("tx soft reset cycles", 32'h1, tc);
        @(posedge mclk);
        txLevel <= 6'h01;
        dmaEn <= 1'b0;
        axWrite(EIF_MODE_ADDR, 8'h41);
        axWrite(EIF_ACK_ADDR, 8'hFF);
        expEvt(8'h00);
        hit(5);
        hit(9);
        expEvt(8'h90);
        expEvt(8'h80);
        axWrite(EIF_ACK_ADDR, 8'h7F);
        expEvt(8'h80);
        axWrite(EIF_ACK_ADDR, 8'h80);
        expEvt(8'h00);
        for (int i = 0; i < 10; i++) begin
            axWrite(EIF_MODE_ADDR, 8'h41 | {4'h0, tblOpm[i], 1'b0});
            axWrite(EIF_ACK_ADDR, 8'hFF);
            @(posedge mclk);
            src[tblSrc[i]] <= 1'b1;
            expEvt(tblExp[i]);
            src[tblSrc[i]] <= 1'b0;
        end
        expEvt(8'h00);
        axWrite(EIF_MODE_ADDR, 8'h55);
        axWrite(EIF_ACK_ADDR, 8'hFF);
        modemDelta <= 4'h2;
        expEvt(8'h00);
        axWrite(EIF_MODE_ADDR, 8'h41);
        expEvt(8'h08);
        finishTest();
    end
endmodule
